// [rtl/lptv_voter.sv]
// Two-of-three voter for output channels 3 and 4 with pushbutton sequencing
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module lptv_voter
	import lptv_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic [3:0]           reg_addr,
	input  wire logic [15:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic [15:0]               reg_rdata,
	output logic                      irq,
	input  wire logic [3*PRESS_W-1:0] press_in,
	input  wire logic                 building_high_pressure_trip,
	input  wire logic [2:0]           bypass_pb,
	input  wire lptv_buttons_t [1:0]  out_pb,
	output logic [2:0]                bypass_light,
	output logic [2:0]                channel_trip_alarm,
	output logic                      bypass_permit_alarm,
	output lptv_lights_t [1:0]        out_lights
);
	lptv_setpoints_t    setp;
	logic [2:0]         ch_trip;
	logic [2:0]         ch_llt;
	logic [2:0]         ch_byp;
	logic [2:0]         ch_prm;
	logic [1:0]         latched;
	logic [1:0]         manual_mode;
	logic [4:0]         irq_status;
	logic [4:0]         irq_mask;
	logic               range_err;
	logic               actuate_q;

	function automatic logic two_of_three(input logic [2:0] v);
		two_of_three = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction : two_of_three

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_ch
			lptv_channel u_ch (
				.clk                         (clk),
				.rst_n                       (rst_n),
				.press_own                   (press_in[g*PRESS_W +: PRESS_W]),
				.press_b                     (press_in[((g+1)%3)*PRESS_W +: PRESS_W]),
				.press_c                     (press_in[((g+2)%3)*PRESS_W +: PRESS_W]),
				.setp                        (setp),
				.building_high_pressure_trip (building_high_pressure_trip),
				.bypass_pb                   (bypass_pb[g]),
				.channel_trip                (ch_trip[g]),
				.low_low_trip                (ch_llt[g]),
				.injection_trip_bypass       (ch_byp[g]),
				.bypass_permit               (ch_prm[g])
			);
		end
	endgenerate

	// Register write decode with range check
	wire        wdata_ok   = reg_wdata[15:12] == 4'h0 && reg_wdata[11:0] <= PRESS_MAX;
	wire        wr_setp    = reg_wr && reg_addr <= ADDR_PERMIT_SETPT;
	wire        wr_bad     = wr_setp && !wdata_ok;
	wire        wr_good    = wr_setp && wdata_ok;
	wire        rd_irq     = reg_rd && reg_addr == ADDR_IRQ_STATUS;
	wire        rd_err     = reg_rd && reg_addr == ADDR_RANGE_ERR;
	// Bypass of two channels masks low-low but not building pressure
	wire        group_byp  = two_of_three(ch_byp);
	wire [2:0]  eff_trip   = (ch_llt & ~{3{group_byp}} & ~ch_byp) | {3{building_high_pressure_trip}};
	wire        auto_act   = two_of_three(eff_trip | (ch_trip & ~{3{group_byp}}));
	wire        all_clear  = !auto_act && !building_high_pressure_trip;
	wire [4:0]  events     = {wr_bad, ch_trip & ~ch_byp, auto_act & ~actuate_q};

	logic [15:0] rd_mux;
	always_comb begin
		unique case (reg_addr)
			ADDR_TRIP_SETPOINT: rd_mux = {4'h0, setp.trip_setpoint};
			ADDR_TRIP_RESET:    rd_mux = {4'h0, setp.trip_reset};
			ADDR_REMOVAL_SETPT: rd_mux = {4'h0, setp.removal_setpoint};
			ADDR_PERMIT_SETPT:  rd_mux = {4'h0, setp.permit_setpoint};
			ADDR_STATUS:        rd_mux = {3'h0, latched, ch_prm, ch_byp, ch_llt, 1'b0, group_byp};
			ADDR_IRQ_STATUS:    rd_mux = {11'h000, irq_status};
			ADDR_IRQ_MASK:      rd_mux = {11'h000, irq_mask};
			ADDR_RANGE_ERR:     rd_mux = {15'h0000, range_err};
			default:            rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			setp       <= {RST_TRIP_SETPOINT, RST_TRIP_RESET, RST_REMOVAL_SETPT, RST_PERMIT_SETPT};
			reg_rdata  <= 16'h0000;
			irq_mask   <= 5'h00;
			irq_status <= 5'h00;
			range_err  <= 1'b0;
			irq        <= 1'b0;
			actuate_q  <= 1'b0;
		end else begin
			if (wr_good && reg_addr == ADDR_TRIP_SETPOINT) setp.trip_setpoint    <= reg_wdata[11:0];
			if (wr_good && reg_addr == ADDR_TRIP_RESET)    setp.trip_reset       <= reg_wdata[11:0];
			if (wr_good && reg_addr == ADDR_REMOVAL_SETPT) setp.removal_setpoint <= reg_wdata[11:0];
			if (wr_good && reg_addr == ADDR_PERMIT_SETPT)  setp.permit_setpoint  <= reg_wdata[11:0];
			if (reg_wr && reg_addr == ADDR_IRQ_MASK)       irq_mask              <= reg_wdata[4:0];
			reg_rdata  <= reg_rd ? rd_mux : 16'h0000;
			// Set wins over the read clear
			irq_status <= (rd_irq ? 5'h00 : irq_status) | events;
			range_err  <= (rd_err ? 1'b0 : range_err) | wr_bad;
			irq        <= |(((rd_irq ? 5'h00 : irq_status) | events) & irq_mask);
			actuate_q  <= auto_act;
		end
	end

	// Per output channel latch, auto/manual and lamps
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_out
			wire do_reset  = out_pb[g].reset_pb && all_clear;
			wire next_lat  = (latched[g] | auto_act | out_pb[g].trip_pb) & ~(do_reset & ~out_pb[g].trip_pb);
			wire next_man  = (manual_mode[g] | out_pb[g].manual_pb) & ~out_pb[g].auto_pb & ~do_reset;
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					latched[g]     <= 1'b0;
					manual_mode[g] <= 1'b0;
					out_lights[g]  <= '0;
				end else begin
					latched[g]     <= next_lat;
					manual_mode[g] <= next_man;
					out_lights[g].trip_light     <= next_lat;
					out_lights[g].manual_light   <= next_man;
					out_lights[g].auto_light     <= ~next_man;
					// Manual trip reaches the relay even in manual mode
					out_lights[g].output_contact <= (next_lat & ~next_man) | out_pb[g].trip_pb;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bypass_light        <= 3'h0;
			channel_trip_alarm  <= 3'h0;
			bypass_permit_alarm <= 1'b0;
		end else begin
			bypass_light        <= ch_byp;
			channel_trip_alarm  <= ch_trip;
			bypass_permit_alarm <= |ch_prm;
		end
	end
endmodule : lptv_voter

// [shared/lptv_pkg.sv]
// Constants and carrier types for the low pressure trip voter
package lptv_pkg;
	localparam int          PRESS_W             = 12;
	localparam logic [11:0] PRESS_MAX           = 12'h09C4;
	localparam logic [11:0] RST_TRIP_SETPOINT   = 12'h0226;
	localparam logic [11:0] RST_TRIP_RESET      = 12'h0244;
	localparam logic [11:0] RST_REMOVAL_SETPT   = 12'h037A;
	localparam logic [11:0] RST_PERMIT_SETPT    = 12'h037A;
	localparam logic [3:0]  ADDR_TRIP_SETPOINT  = 4'h0;
	localparam logic [3:0]  ADDR_TRIP_RESET     = 4'h1;
	localparam logic [3:0]  ADDR_REMOVAL_SETPT  = 4'h2;
	localparam logic [3:0]  ADDR_PERMIT_SETPT   = 4'h3;
	localparam logic [3:0]  ADDR_STATUS         = 4'h4;
	localparam logic [3:0]  ADDR_IRQ_STATUS     = 4'h5;
	localparam logic [3:0]  ADDR_IRQ_MASK       = 4'h6;
	localparam logic [3:0]  ADDR_RANGE_ERR      = 4'h7;
	localparam int          IRQ_ACTUATION       = 0;
	localparam int          IRQ_TRIP_A          = 1;
	localparam int          IRQ_RANGE_ERR       = 4;

	typedef struct packed {
		logic [11:0] trip_setpoint;
		logic [11:0] trip_reset;
		logic [11:0] removal_setpoint;
		logic [11:0] permit_setpoint;
	} lptv_setpoints_t;

	typedef struct packed {
		logic trip_pb;
		logic reset_pb;
		logic auto_pb;
		logic manual_pb;
	} lptv_buttons_t;

	typedef struct packed {
		logic trip_light;
		logic auto_light;
		logic manual_light;
		logic output_contact;
	} lptv_lights_t;
endpackage : lptv_pkg

// [rtl/lptv_channel.sv]
// One instrument channel: second-lowest pick, comparators, bypass
`timescale 1ns/1ps
module lptv_channel
	import lptv_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic [PRESS_W-1:0]   press_own,
	input  wire logic [PRESS_W-1:0]   press_b,
	input  wire logic [PRESS_W-1:0]   press_c,
	input  wire lptv_setpoints_t      setp,
	input  wire logic                 building_high_pressure_trip,
	input  wire logic                 bypass_pb,
	output logic                      channel_trip,
	output logic                      low_low_trip,
	output logic                      injection_trip_bypass,
	output logic                      bypass_permit
);
	function automatic logic [PRESS_W-1:0] mid3(input logic [PRESS_W-1:0] a, b, c);
		logic [PRESS_W-1:0] lo;
		logic [PRESS_W-1:0] hi;
		lo = (a < b) ? a : b;
		hi = (a < b) ? b : a;
		mid3 = (c <= lo) ? lo : ((c >= hi) ? hi : c);
	endfunction : mid3

	logic              removal_active;
	wire [PRESS_W-1:0] second_lowest_pressure = mid3(press_own, press_b, press_c);
	wire               at_trip   = second_lowest_pressure <= setp.trip_setpoint;
	wire               above_rst = second_lowest_pressure > setp.trip_reset;
	wire               at_remove = second_lowest_pressure >= setp.removal_setpoint;
	wire               below_prm = second_lowest_pressure < setp.permit_setpoint;
	wire               next_llt  = at_trip | (low_low_trip & ~above_rst);
	wire               next_rem  = at_remove | (removal_active & ~below_prm);
	// Bypass only while the removal comparator is clear
	wire               next_byp  = ~next_rem & (injection_trip_bypass | (bypass_pb & below_prm));

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			low_low_trip          <= 1'b0;
			removal_active        <= 1'b1;
			injection_trip_bypass <= 1'b0;
			bypass_permit         <= 1'b0;
			channel_trip          <= 1'b0;
		end else begin
			low_low_trip          <= next_llt;
			removal_active        <= next_rem;
			injection_trip_bypass <= next_byp;
			bypass_permit         <= ~next_rem;
			// High building pressure is never bypassed
			channel_trip          <= (next_llt & ~next_byp) | building_high_pressure_trip;
		end
	end
endmodule : lptv_channel

// [testbench/lptv_voter_sva.sv]
// Checker for the voter's register port, channel alarms and output lights
`timescale 1ns/1ps
module lptv_voter_sva
	import lptv_pkg::*;
(
	input wire logic                 clk,
	input wire logic                 rst_n,
	input wire logic                 reg_rd,
	input wire logic [15:0]          reg_rdata,
	input wire logic [3*PRESS_W-1:0] press_in,
	input wire logic                 building_high_pressure_trip,
	input wire lptv_buttons_t [1:0]  out_pb,
	input wire logic [2:0]           bypass_light,
	input wire logic [2:0]           channel_trip_alarm,
	input wire lptv_lights_t [1:0]   out_lights
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Count of readings at or below a limit; two or more decides the middle value
	// Pressures go in as an argument, or the wires would never re-evaluate
	function automatic logic [1:0] n_le(input logic [35:0] p, input logic [11:0] lim);
		n_le = 2'(p[11:0] <= lim) + 2'(p[23:12] <= lim) + 2'(p[35:24] <= lim);
	endfunction : n_le
	wire lo2  = n_le(press_in, RST_TRIP_SETPOINT) >= 2'd2;
	wire clr2 = n_le(press_in, RST_TRIP_RESET) <= 2'd1;
	wire hi2  = n_le(press_in, RST_REMOVAL_SETPT - 12'h0001) <= 2'd1;
	wire both_trip = out_lights[0].trip_light && out_lights[1].trip_light;
	// Comparators take two edges, so the cause must hold a while first
	sequence s_low; (lo2 && bypass_light == 3'b000)[*4]; endsequence
	property p_rd_quiet; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside its cycle");
	property p_low_trip; s_low |-> channel_trip_alarm == 3'b111; endproperty
	a_low_trip: assert property (p_low_trip) else $error("no trip at low middle pressure");
	property p_clear; (clr2 && !building_high_pressure_trip)[*5] |-> channel_trip_alarm == 3'b000; endproperty
	a_clear: assert property (p_clear) else $error("trip did not clear");
	property p_vote; $countones(channel_trip_alarm) >= 2 && bypass_light == 3'b000 |-> ##[1:3] both_trip; endproperty
	a_vote: assert property (p_vote) else $error("two trips gave no actuation");
	property p_bhp_act; $rose(building_high_pressure_trip) |-> ##[1:4] both_trip; endproperty
	a_bhp_act: assert property (p_bhp_act) else $error("building trip gave no actuation");
	property p_removal; hi2[*5] |-> bypass_light == 3'b000; endproperty
	a_removal: assert property (p_removal) else $error("bypass stayed at high pressure");
	property p_man_trip; out_pb[0].trip_pb |=> out_lights[0].output_contact; endproperty
	a_man_trip: assert property (p_man_trip) else $error("manual trip did not close contact");
	property p_manual; out_pb[0].manual_pb && !out_pb[0].trip_pb |=> out_lights[0] == 4'b1010
		|| out_lights[0] == 4'b0010; endproperty
	a_manual: assert property (p_manual) else $error("manual lights or contact wrong");
	property p_reset; out_pb[0].reset_pb && !out_pb[0].trip_pb && !building_high_pressure_trip
		&& $countones(bypass_light) >= 2 |=> !out_lights[0].trip_light && !out_lights[0].manual_light; endproperty
	a_reset: assert property (p_reset) else $error("reset left lights on");
	property p_bhp_hold; building_high_pressure_trip && out_lights[1].trip_light |=> out_lights[1].trip_light;
	endproperty
	a_bhp_hold: assert property (p_bhp_hold) else $error("trip cleared during building trip");
endmodule : lptv_voter_sva
bind lptv_voter lptv_voter_sva u_sva (.clk, .rst_n, .reg_rd, .reg_rdata, .press_in, .building_high_pressure_trip,
	.out_pb, .bypass_light, .channel_trip_alarm, .out_lights);

// [testbench/lptv_panel.sv]
// Operator panel model: bypass and output-channel pushbuttons
`timescale 1ns/1ps
module lptv_panel
	import lptv_pkg::*;
(
	input  wire logic           clk,
	output logic [2:0]          bypass_pb,
	output lptv_buttons_t [1:0] out_pb
);
	initial begin
		bypass_pb = 3'b000;
		out_pb = '0;
	end
	// Levels, since a real button stays down as long as the operator holds it
	task automatic hold_bypass(input logic [2:0] m);
		@(posedge clk) bypass_pb <= m;
	endtask : hold_bypass
	// One-cycle press; bit order trip, reset, auto, manual
	task automatic push(input int ch, input logic [3:0] b);
		@(posedge clk) out_pb[ch] <= b;
		@(posedge clk) out_pb[ch] <= 4'h0;
	endtask : push
endmodule : lptv_panel

// [testbench/test_low_pressure_trip_voter.sv]
// Self-checking bench for the low pressure trip voter
`timescale 1ns/1ps
module test_low_pressure_trip_voter;
	import lptv_pkg::*;
	logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, building_high_pressure_trip = 0, irq, bypass_permit_alarm;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata;
	logic [35:0] press_in = {3{12'h03E8}};
	logic [2:0] bypass_pb, bypass_light, channel_trip_alarm;
	lptv_buttons_t [1:0] out_pb;
	lptv_lights_t [1:0] out_lights;
	int mismatches = 0, comparisons = 0, cycles = 0;
	lptv_voter DUT (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .press_in,
		.building_high_pressure_trip, .bypass_pb, .out_pb, .bypass_light, .channel_trip_alarm,
		.bypass_permit_alarm, .out_lights);
	lptv_panel panel (.clk, .bypass_pb, .out_pb);
	always #20 clk = ~clk;
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done
	// Generous ceiling; the whole run needs about a hundred and five cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			test_done();
		end
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : w
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 check(reg_rdata, e);
	endtask : rd
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd(ADDR_TRIP_SETPOINT, 16'h0226);
		rd(ADDR_TRIP_RESET, {4'h0, RST_TRIP_RESET});
		rd(ADDR_REMOVAL_SETPT, 16'h037A);
		rd(ADDR_PERMIT_SETPT, {4'h0, RST_PERMIT_SETPT});
		wr(ADDR_IRQ_MASK, 16'h0010);
		rd(ADDR_IRQ_MASK, 16'h0010);
		wr(ADDR_TRIP_SETPOINT, 16'h09C5);
		rd(ADDR_TRIP_SETPOINT, 16'h0226);
		check({15'h0, irq}, 16'h0001);
		rd(ADDR_IRQ_STATUS, 16'h0010);
		rd(ADDR_RANGE_ERR, 16'h0001);
		rd(ADDR_RANGE_ERR, 16'h0000);
		w(2);
		check({15'h0, irq}, 16'h0000);
		wr(ADDR_REMOVAL_SETPT, 16'h09C4);
		rd(ADDR_REMOVAL_SETPT, 16'h09C4);
		wr(ADDR_REMOVAL_SETPT, 16'h037A);
		wr(ADDR_TRIP_RESET, 16'h0258);
		rd(ADDR_TRIP_RESET, 16'h0258);
		rd(4'hF, 16'h0000);
		@(posedge clk) press_in <= {12'h03E8, 12'h03E8, 12'h01F4};
		w(6);
		check({13'h0, channel_trip_alarm}, 16'h0000);
		@(posedge clk) press_in <= {12'h03E8, 12'h0226, 12'h01F4};
		w(6);
		check({13'h0, channel_trip_alarm}, 16'h0007);
		check({14'h0, out_lights[1].trip_light, out_lights[0].trip_light}, 16'h0003);
		check({15'h0, bypass_permit_alarm}, 16'h0001);
		panel.hold_bypass(3'b111);
		w(4);
		check({13'h0, bypass_light}, 16'h0007);
		@(posedge clk) building_high_pressure_trip <= 1'b1;
		panel.push(1, 4'b0100);
		w(2);
		check({15'h0, out_lights[1].trip_light}, 16'h0001);
		@(posedge clk) building_high_pressure_trip <= 1'b0;
		panel.hold_bypass(3'b000);
		panel.push(0, 4'b0001);
		w(2);
		check({12'h0, out_lights[0]}, 16'h000A);
		panel.push(0, 4'b0100);
		w(2);
		check({14'h0, out_lights[0].trip_light, out_lights[0].manual_light}, 16'h0000);
		panel.push(0, 4'b1000);
		w(2);
		check({14'h0, out_lights[0].trip_light, out_lights[0].output_contact}, 16'h0003);
		@(posedge clk) press_in <= {3{12'h03E8}};
		w(8);
		check({13'h0, bypass_light}, 16'h0000);
		check({13'h0, channel_trip_alarm}, 16'h0000);
		check({15'h0, bypass_permit_alarm}, 16'h0000);
		@(posedge clk) press_in <= {3{12'h0320}};
		w(6);
		panel.hold_bypass(3'b011);
		w(4);
		check({13'h0, bypass_light}, 16'h0003);
		rd(ADDR_STATUS, 16'h1F61);
		rd(ADDR_IRQ_STATUS, 16'h000F);
		test_done();
	end
endmodule : test_low_pressure_trip_voter
